// ===== dcp_param_map.sv
// common parameter map of the drive: word registers, command edges and status
// ---------------------------------------------------------------
// Notes on behaviour
// RQ1 - common map offsets fixed regardless of model variant
// RQ2 - rating word reports rating code 0 to 0x17
// RQ3 - supply class word reads 0 low class, 1 high class
// RQ4 - firmware version word read-only, packed hex, e.g. 0x0100
// RQ5 - run word bits 0,1,2 request stop, forward, reverse
// RQ6 - fault latch clears only on rising edge of run word bit 3
// RQ7 - bit 4 commands emergency stop; bit 5 ignored
// RQ8 - bits 7:6 report run/stop command source
// RQ9 - bits 14:8 report frequency source; 0-16 multi-step
// RQ10 - codes 17-19 raise/lower modes; 20-21 reserved
// RQ11 - codes 22-25 analog reference choices
// RQ12 - codes 26-31 pulse, auxiliary, serial, option, jog, process controller
// RQ13 - bit 15 set whenever a network error is detected
// RQ14 - status bits 0,1,2 stopped, forward, reverse
// RQ15 - status bits 3,4,5 fault, accelerating, decelerating
// RQ16 - measurement words read-only unsigned in fixed unit steps
// RQ17 - 16-bit words; read-only ignores writes; read/write keeps value
// RQ18 - stop and forward take effect on zero-to-one bit change
// RQ19 - write to read-only or run-locked word refused, write-mode error
// RQ20 - out-of-range value refused with illegal-value error
// RQ21 - unknown address answered with illegal-address error
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "dcp_consts.svh"
module dcp_param_map (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire dcp_pkg::dcp_word_t req_addr,
	input wire dcp_pkg::dcp_word_t req_wdata,
	output logic rsp_valid,
	output dcp_pkg::dcp_word_t rsp_rdata,
	output dcp_pkg::dcp_err_e rsp_err,
	input wire logic [4:0] rating_code,
	input wire logic supply_high,
	input wire dcp_pkg::dcp_src_e cmd_source,
	input wire logic [6:0] freq_source,
	input wire logic net_error,
	input wire logic fault_event,
	input wire logic motor_running,
	input wire logic motor_reverse,
	input wire logic motor_accel,
	input wire logic motor_decel,
	input wire dcp_pkg::dcp_word_t meas_current,
	input wire dcp_pkg::dcp_word_t meas_frequency,
	input wire dcp_pkg::dcp_word_t meas_voltage,
	input wire dcp_pkg::dcp_word_t meas_link_voltage,
	input wire dcp_pkg::dcp_word_t meas_power,
	output logic stop_cmd,
	output logic fwd_cmd,
	output logic rev_cmd,
	output logic estop_cmd,
	output logic fault_active,
	output dcp_pkg::dcp_word_t speed_setpoint,
	output dcp_pkg::dcp_word_t ramp_up_time,
	output dcp_pkg::dcp_word_t ramp_down_time
);
	import dcp_pkg::*;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	dcp_err_e dec_err;
	logic [13:0] sel;
	dcp_decode u_decode (
		.addr(req_addr),
		.wdata(req_wdata),
		.is_write(req_write),
		.running(motor_running),
		.err(dec_err), // RQ1 RQ19 RQ20 RQ21
		.sel(sel)
	);

	wire wr_ok = req_valid & req_write & (dec_err == DCP_OK); // RQ17
	wire wr_rc = wr_ok & sel[5];

	// ---------------------------------------------------------------
	// writable words
	// ---------------------------------------------------------------
	dcp_word_t setpoint_q, ramp_up_q, ramp_dn_q;
	logic [4:0] rc_cmd_q;
	logic net_err_q, fault_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			setpoint_q <= `DCP_SETPOINT_RST;
			ramp_up_q <= `DCP_RAMP_RST;
			ramp_dn_q <= `DCP_RAMP_RST;
			rc_cmd_q <= 5'h00;
		end else begin
			if (wr_ok && sel[4]) setpoint_q <= req_wdata; // RQ17
			if (wr_ok && sel[6]) ramp_up_q <= req_wdata;
			if (wr_ok && sel[7]) ramp_dn_q <= req_wdata;
			if (wr_rc) rc_cmd_q <= req_wdata[4:0]; // RQ7
		end
	end

	// ---------------------------------------------------------------
	// command edges
	// ---------------------------------------------------------------
	logic [4:0] rc_rise;
	dcp_rise u_rise (
		.clk(clk),
		.rst_n(rst_n),
		.level(rc_cmd_q),
		.rise(rc_rise)
	);

	logic stop_q, fwd_q, rev_q, estop_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stop_q <= 1'b0;
			fwd_q <= 1'b0;
			rev_q <= 1'b0;
			estop_q <= 1'b0;
		end else begin
			stop_q <= rc_rise[`DCP_RC_STOP]; // RQ5 RQ18
			fwd_q <= rc_rise[`DCP_RC_FWD]; // RQ5 RQ18
			rev_q <= rc_rise[`DCP_RC_REV]; // RQ5
			estop_q <= rc_cmd_q[`DCP_RC_ESTOP]; // RQ7
		end
	end

	wire frst_rise = rc_rise[`DCP_RC_FRST];

	// fault set wins over a coincident reset edge so no trip is lost
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
		end else if (fault_event) begin
			fault_q <= 1'b1;
		end else if (frst_rise) begin
			fault_q <= 1'b0; // RQ6
		end
	end

	// network error stays set until the master rewrites the run word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			net_err_q <= 1'b0;
		end else if (net_error) begin
			net_err_q <= 1'b1; // RQ13
		end else if (wr_rc) begin
			net_err_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// read words
	// ---------------------------------------------------------------
	wire [15:0] rating_w = (16'(rating_code) > `DCP_RATING_MAX) ? `DCP_RATING_MAX : 16'(rating_code); // RQ2
	wire [15:0] supply_w = supply_high ? `DCP_SUPPLY_MAX : 16'h0000; // RQ3
	wire [6:0] fsrc_w = (freq_source > `DCP_FSRC_MAX) ? `DCP_FSRC_MAX : freq_source; // RQ9 RQ10 RQ11 RQ12
	wire [15:0] runctl_w = {net_err_q, fsrc_w, 2'(cmd_source), 1'b0, rc_cmd_q}; // RQ8 RQ9 RQ13
	wire stopped_w = ~motor_running;
	wire [15:0] state_w = {10'h000, motor_decel, motor_accel, fault_q,
		motor_running & motor_reverse, motor_running & ~motor_reverse, stopped_w}; // RQ14 RQ15

	wire [15:0] rd_mux =
		sel[0] ? `DCP_MODEL_ID :
		sel[1] ? rating_w :
		sel[2] ? supply_w :
		sel[3] ? `DCP_FWVER_VAL : // RQ4
		sel[4] ? setpoint_q :
		sel[5] ? runctl_w :
		sel[6] ? ramp_up_q :
		sel[7] ? ramp_dn_q :
		sel[8] ? meas_current : // RQ16
		sel[9] ? meas_frequency :
		sel[10] ? meas_voltage :
		sel[11] ? meas_link_voltage :
		sel[12] ? meas_power :
		sel[13] ? state_w : 16'h0000;

	// ---------------------------------------------------------------
	// response
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
			rsp_err <= DCP_OK;
		end else begin
			rsp_valid <= req_valid;
			// a write answers with the old contents of the word
			rsp_rdata <= req_valid ? rd_mux : 16'h0000;
			rsp_err <= req_valid ? dec_err : DCP_OK; // RQ19 RQ20 RQ21
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			speed_setpoint <= `DCP_SETPOINT_RST;
			ramp_up_time <= `DCP_RAMP_RST;
			ramp_down_time <= `DCP_RAMP_RST;
		end else begin
			speed_setpoint <= setpoint_q;
			ramp_up_time <= ramp_up_q;
			ramp_down_time <= ramp_dn_q;
		end
	end

	assign stop_cmd = stop_q;
	assign fwd_cmd = fwd_q;
	assign rev_cmd = rev_q;
	assign estop_cmd = estop_q;
	assign fault_active = fault_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_rc_write_rise(int b);
		wr_rc && req_wdata[b] && !rc_cmd_q[b];
	endsequence

	sequence s_read(int k);
		req_valid && !req_write && sel[k];
	endsequence

	property p_stop_edge;
		@(posedge clk) disable iff (!rst_n) s_rc_write_rise(0) |-> ##2 stop_cmd ##1 !stop_cmd;
	endproperty
	a_stop_edge: assert property (p_stop_edge) else $error("stop pulse missing"); // RQ18

	property p_fwd_edge;
		@(posedge clk) disable iff (!rst_n) s_rc_write_rise(1) |-> ##2 fwd_cmd;
	endproperty
	a_fwd_edge: assert property (p_fwd_edge) else $error("forward pulse missing"); // RQ5

	property p_fault_clear;
		@(posedge clk) disable iff (!rst_n) (fault_q && !fault_event && !$past(fault_event)) ##1 !fault_q |-> $past(frst_rise);
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without reset edge"); // RQ6

	property p_fault_set;
		@(posedge clk) disable iff (!rst_n) fault_event |=> fault_active;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not latched"); // RQ15

	property p_net_err;
		@(posedge clk) disable iff (!rst_n) net_error |-> ##1 net_err_q ##0 runctl_w[15];
	endproperty
	a_net_err: assert property (p_net_err) else $error("network error bit not set"); // RQ13

	property p_ro_kept;
		@(posedge clk) disable iff (!rst_n) (req_valid && req_write && sel[3]) |=> rsp_err == DCP_ERR_WMODE;
	endproperty
	a_ro_kept: assert property (p_ro_kept) else $error("read-only write not refused"); // RQ19

	property p_bad_addr;
		@(posedge clk) disable iff (!rst_n) (req_valid && !(|sel)) |=> rsp_valid && rsp_err == DCP_ERR_ADDR;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unknown address not flagged"); // RQ21

	property p_ramp_range;
		@(posedge clk) disable iff (!rst_n) (wr_ok && sel[6]) |-> req_wdata <= `DCP_RAMP_MAX ##2 ramp_up_time == $past(req_wdata, 2);
	endproperty
	a_ramp_range: assert property (p_ramp_range) else $error("ramp value out of range stored"); // RQ20

	property p_state_bits;
		@(posedge clk) disable iff (!rst_n) s_read(13) |=> rsp_rdata[0] == !$past(motor_running)
			&& rsp_rdata[3] == $past(fault_q) && rsp_rdata[2:1] != 2'b11;
	endproperty
	a_state_bits: assert property (p_state_bits) else $error("status bits inconsistent"); // RQ14

	property p_state_motion;
		@(posedge clk) disable iff (!rst_n) s_read(13) |=> rsp_rdata[5] == $past(motor_decel)
			&& rsp_rdata[4] == $past(motor_accel);
	endproperty
	a_state_motion: assert property (p_state_motion) else $error("ramp status bits wrong"); // RQ15

	property p_rev_edge;
		@(posedge clk) disable iff (!rst_n) s_rc_write_rise(2) |-> ##2 rev_cmd ##1 !rev_cmd;
	endproperty
	a_rev_edge: assert property (p_rev_edge) else $error("reverse pulse missing"); // RQ5

	property p_estop_on;
		@(posedge clk) disable iff (!rst_n) (wr_rc && req_wdata[`DCP_RC_ESTOP]) |-> ##2 estop_cmd;
	endproperty
	a_estop_on: assert property (p_estop_on) else $error("emergency stop not raised"); // RQ7

	property p_estop_off;
		@(posedge clk) disable iff (!rst_n) (wr_rc && !req_wdata[`DCP_RC_ESTOP]) |-> ##2 !estop_cmd;
	endproperty
	a_estop_off: assert property (p_estop_off) else $error("emergency stop not dropped"); // RQ7

	property p_bit5_clear;
		@(posedge clk) disable iff (!rst_n) s_read(5) |=> !rsp_rdata[5];
	endproperty
	a_bit5_clear: assert property (p_bit5_clear) else $error("unused run word bit reads set"); // RQ7

	property p_model_id;
		@(posedge clk) disable iff (!rst_n) s_read(0) |=> rsp_rdata == `DCP_MODEL_ID && rsp_err == DCP_OK;
	endproperty
	a_model_id: assert property (p_model_id) else $error("model word wrong"); // RQ1

	property p_rating_max;
		@(posedge clk) disable iff (!rst_n) s_read(1) |=> rsp_rdata <= `DCP_RATING_MAX;
	endproperty
	a_rating_max: assert property (p_rating_max) else $error("rating code above largest step"); // RQ2

	property p_supply_class;
		@(posedge clk) disable iff (!rst_n) s_read(2) |=> rsp_rdata == {15'h0000, $past(supply_high)};
	endproperty
	a_supply_class: assert property (p_supply_class) else $error("supply class word wrong"); // RQ3

	property p_fwver;
		@(posedge clk) disable iff (!rst_n) s_read(3) |=> rsp_rdata == `DCP_FWVER_VAL;
	endproperty
	a_fwver: assert property (p_fwver) else $error("firmware word wrong"); // RQ4

	property p_fsrc_range;
		@(posedge clk) disable iff (!rst_n) s_read(5) |=> rsp_rdata[14:8] <= `DCP_FSRC_MAX;
	endproperty
	a_fsrc_range: assert property (p_fsrc_range) else $error("frequency source code out of range"); // RQ9 RQ10 RQ11 RQ12

	property p_ramp_locked;
		@(posedge clk) disable iff (!rst_n)
			(req_valid && req_write && (sel[6] || sel[7]) && motor_running) |=> rsp_err == DCP_ERR_WMODE;
	endproperty
	a_ramp_locked: assert property (p_ramp_locked) else $error("ramp write while running not refused"); // RQ19

	property p_ramp_value;
		@(posedge clk) disable iff (!rst_n)
			(req_valid && req_write && sel[7] && !motor_running && req_wdata > `DCP_RAMP_MAX)
			|=> rsp_err == DCP_ERR_VALUE;
	endproperty
	a_ramp_value: assert property (p_ramp_value) else $error("ramp value out of range not refused"); // RQ20

	property p_meas_ro;
		@(posedge clk) disable iff (!rst_n) (req_valid && req_write && (|sel[12:8])) |=> rsp_err == DCP_ERR_WMODE;
	endproperty
	a_meas_ro: assert property (p_meas_ro) else $error("measurement write not refused"); // RQ16

	property p_rsp_follow;
		@(posedge clk) disable iff (!rst_n) 1'b1 |=> rsp_valid == $past(req_valid);
	endproperty
	a_rsp_follow: assert property (p_rsp_follow) else $error("answer strobe out of step"); // RQ17

	property p_setpoint_kept;
		@(posedge clk) disable iff (!rst_n) (wr_ok && sel[4]) |-> ##2 speed_setpoint == $past(req_wdata, 2);
	endproperty
	a_setpoint_kept: assert property (p_setpoint_kept) else $error("setpoint write not kept"); // RQ17

	property p_fault_hold;
		@(posedge clk) disable iff (!rst_n) (fault_q && !frst_rise) |=> fault_q;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without reset edge"); // RQ6

	property p_net_hold;
		@(posedge clk) disable iff (!rst_n) (net_err_q && !wr_rc) |=> net_err_q;
	endproperty
	a_net_hold: assert property (p_net_hold) else $error("network error bit lost"); // RQ13
endmodule // dcp_param_map
`default_nettype wire

// ===== dcp_consts.svh
// offsets, field positions, reset values and limits of the drive parameter map
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH

`define DCP_ADDR_MODEL 16'h0000
`define DCP_ADDR_RATING 16'h0001
`define DCP_ADDR_SUPPLY 16'h0002
`define DCP_ADDR_FWVER 16'h0003
`define DCP_ADDR_SETPOINT 16'h0005
`define DCP_ADDR_RUNCTL 16'h0006
`define DCP_ADDR_RAMPUP 16'h0007
`define DCP_ADDR_RAMPDN 16'h0008
`define DCP_ADDR_CURRENT 16'h0009
`define DCP_ADDR_FREQ 16'h000a
`define DCP_ADDR_VOLT 16'h000b
`define DCP_ADDR_LINKV 16'h000c
`define DCP_ADDR_POWER 16'h000d
`define DCP_ADDR_STATE 16'h000e

`define DCP_RC_STOP 0
`define DCP_RC_FWD 1
`define DCP_RC_REV 2
`define DCP_RC_FRST 3
`define DCP_RC_ESTOP 4
`define DCP_RC_SRC_LO 6
`define DCP_RC_SRC_HI 7
`define DCP_RC_FSRC_LO 8
`define DCP_RC_FSRC_HI 14
`define DCP_RC_NETERR 15
// bits of the run-control word the master may change
`define DCP_RC_WMASK 16'h001f

`define DCP_ST_STOP 0
`define DCP_ST_FWD 1
`define DCP_ST_REV 2
`define DCP_ST_FAULT 3
`define DCP_ST_ACC 4
`define DCP_ST_DEC 5

`define DCP_RATING_MAX 16'h0017
`define DCP_SUPPLY_MAX 16'h0001
`define DCP_FSRC_MAX 7'h1f
`define DCP_SETPOINT_RST 16'h0000
`define DCP_RAMP_RST 16'h0064
`define DCP_SETPOINT_MAX 16'hffff
`define DCP_RAMP_MAX 16'h1770
// arbitrary neutral identity value
`define DCP_MODEL_ID 16'h00a5
`define DCP_FWVER_VAL 16'h0100

`endif

// ===== dcp_pkg.sv
// types shared by the drive parameter map
`default_nettype none
package dcp_pkg;
	typedef enum logic [1:0] {DCP_OK, DCP_ERR_ADDR, DCP_ERR_WMODE, DCP_ERR_VALUE} dcp_err_e;
	typedef enum logic [1:0] {DCP_SRC_TERMINAL, DCP_SRC_KEYPAD, DCP_SRC_OPTION, DCP_SRC_SERIAL} dcp_src_e;
	typedef logic [15:0] dcp_word_t;
endpackage
`default_nettype wire

// ===== dcp_decode.sv
// address decode and write legality check of the drive parameter map
`timescale 1ns/10ps
`default_nettype none
`include "dcp_consts.svh"
module dcp_decode (
	input wire dcp_pkg::dcp_word_t addr,
	input wire dcp_pkg::dcp_word_t wdata,
	input wire logic is_write,
	input wire logic running,
	output dcp_pkg::dcp_err_e err,
	output logic [13:0] sel
);
	import dcp_pkg::*;

	wire [15:0] map_addr [0:13];
	assign map_addr[0] = `DCP_ADDR_MODEL;
	assign map_addr[1] = `DCP_ADDR_RATING;
	assign map_addr[2] = `DCP_ADDR_SUPPLY;
	assign map_addr[3] = `DCP_ADDR_FWVER;
	assign map_addr[4] = `DCP_ADDR_SETPOINT;
	assign map_addr[5] = `DCP_ADDR_RUNCTL;
	assign map_addr[6] = `DCP_ADDR_RAMPUP;
	assign map_addr[7] = `DCP_ADDR_RAMPDN;
	assign map_addr[8] = `DCP_ADDR_CURRENT;
	assign map_addr[9] = `DCP_ADDR_FREQ;
	assign map_addr[10] = `DCP_ADDR_VOLT;
	assign map_addr[11] = `DCP_ADDR_LINKV;
	assign map_addr[12] = `DCP_ADDR_POWER;
	assign map_addr[13] = `DCP_ADDR_STATE;

	wire [13:0] match;
	genvar i;
	generate
		for (i = 0; i < 14; i = i + 1) begin : g_sel
			assign match[i] = (addr == map_addr[i]);
		end
	endgenerate
	assign sel = match;

	wire hit = |sel;
	wire writable = sel[4] | sel[5] | sel[6] | sel[7];
	// ramp times cannot be retuned while the motor turns
	wire run_locked = running & (sel[6] | sel[7]);
	wire ramp_bad = (sel[6] | sel[7]) & (wdata > `DCP_RAMP_MAX);
	// run word bits above the command bits are dropped, so no run word value is illegal

	assign err = !hit ? DCP_ERR_ADDR :
		(!is_write ? DCP_OK :
		((!writable || run_locked) ? DCP_ERR_WMODE :
		(ramp_bad ? DCP_ERR_VALUE : DCP_OK)));
endmodule // dcp_decode
`default_nettype wire

// ===== dcp_rise.sv
// rising-edge pulse detector for command bits
`timescale 1ns/10ps
`default_nettype none
module dcp_rise (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] level,
	output logic [4:0] rise
);
	logic [4:0] prev_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_q <= 5'h00;
		end else begin
			prev_q <= level;
		end
	end
	assign rise = level & ~prev_q;
endmodule // dcp_rise
`default_nettype wire

// ===== dcp_master_model.sv
// serial master model issuing word requests to the parameter map
`timescale 1ns/10ps
`default_nettype none
module dcp_master_model (
	input wire logic clk,
	output logic req_valid,
	output logic req_write,
	output dcp_pkg::dcp_word_t req_addr,
	output dcp_pkg::dcp_word_t req_wdata,
	input wire logic rsp_valid,
	input wire dcp_pkg::dcp_word_t rsp_rdata,
	input wire dcp_pkg::dcp_err_e rsp_err
);
	import dcp_pkg::*;
	logic seen;
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
		seen = 1'b0;
	end
	// held over the taking edge; idle lines get inverted so stale values never look valid
	task automatic xfer(input logic w, input dcp_word_t a, input dcp_word_t d, output dcp_word_t rd,
		output dcp_err_e e);
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		req_addr = ~a;
		req_wdata = ~d;
		seen = rsp_valid;
		rd = rsp_rdata;
		e = rsp_err;
	endtask
endmodule // dcp_master_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench of the drive parameter map
`timescale 1ns/10ps
`default_nettype none
`include "dcp_consts.svh"
module tb_top;
	import dcp_pkg::*;
	logic clk, rst_n, req_valid, req_write, rsp_valid, supply_high, net_error, fault_event;
	logic motor_running, motor_reverse, motor_accel, motor_decel;
	logic stop_cmd, fwd_cmd, rev_cmd, estop_cmd, fault_active;
	logic [4:0] rating_code;
	logic [6:0] freq_source;
	logic [6:0] fs [10] = '{7'h00, 7'h10, 7'h11, 7'h13, 7'h14, 7'h16, 7'h19, 7'h1a, 7'h1f, 7'h7f};
	dcp_src_e cmd_source;
	dcp_word_t req_addr, req_wdata, rsp_rdata, speed_setpoint, ramp_up_time, ramp_down_time, rd, ex;
	dcp_word_t meas [5] = '{16'h0123, 16'h1388, 16'h017c, 16'h0226, 16'h00f0};
	dcp_word_t st_ex [4] = '{16'h0011, 16'h0002, 16'h0031, 16'h0024};
	dcp_err_e rsp_err, er;
	int n_errors = 0;
	int checks = 0;

	dcp_param_map dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_err(rsp_err), .rating_code(rating_code), .supply_high(supply_high), .cmd_source(cmd_source),
		.freq_source(freq_source), .net_error(net_error), .fault_event(fault_event),
		.motor_running(motor_running), .motor_reverse(motor_reverse), .motor_accel(motor_accel),
		.motor_decel(motor_decel), .meas_current(meas[0]), .meas_frequency(meas[1]), .meas_voltage(meas[2]),
		.meas_link_voltage(meas[3]), .meas_power(meas[4]), .stop_cmd(stop_cmd), .fwd_cmd(fwd_cmd),
		.rev_cmd(rev_cmd), .estop_cmd(estop_cmd), .fault_active(fault_active),
		.speed_setpoint(speed_setpoint), .ramp_up_time(ramp_up_time), .ramp_down_time(ramp_down_time));
	dcp_master_model mm (.clk(clk), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err));

	// ----
	// tasks
	// ----
	task automatic chk(input string what, input dcp_word_t exp, input dcp_word_t got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(input logic w, input dcp_word_t a, input dcp_word_t d, input dcp_err_e e);
		mm.xfer(w, a, d, rd, er);
		chk("answer strobe", 16'h0001, {15'h0, mm.seen});
		chk("answer code", {14'h0, e}, {14'h0, er});
	endtask
	task automatic rd_chk(input dcp_word_t a, input dcp_word_t exp);
		acc(1'b0, a, 16'h0000, DCP_OK);
		chk("read data", exp, rd);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("ERROR watchdog expected end seen hang");
		print_verdict;
	end

	// ----
	// tests
	// ----
	initial begin
		{rst_n, supply_high, net_error, fault_event, rating_code, freq_source} = '0;
		{motor_running, motor_reverse, motor_accel, motor_decel} = 4'h0;
		cmd_source = DCP_SRC_TERMINAL;
		step(20);
		rst_n = 1'b1;
		rd_chk(`DCP_ADDR_RAMPUP, 16'h0064);
		rd_chk(`DCP_ADDR_SETPOINT, 16'h0000);
		rd_chk(`DCP_ADDR_MODEL, `DCP_MODEL_ID);
		rd_chk(`DCP_ADDR_FWVER, 16'h0100);
		acc(1'b1, `DCP_ADDR_FWVER, 16'h0101, DCP_ERR_WMODE);
		rd_chk(`DCP_ADDR_FWVER, 16'h0100);
		for (int i = 0; i < 3; i++) begin
			rating_code = (i == 0) ? 5'h00 : ((i == 1) ? 5'h17 : 5'h1f);
			supply_high = i[0];
			rd_chk(`DCP_ADDR_RATING, (i == 0) ? 16'h0000 : 16'h0017);
			rd_chk(`DCP_ADDR_SUPPLY, {15'h0, i[0]});
		end
		$display("test identity done");
		for (int b = 0; b < 3; b++) begin
			acc(1'b1, `DCP_ADDR_RUNCTL, 16'h0000, DCP_OK);
			acc(1'b1, `DCP_ADDR_RUNCTL, 16'(1 << b), DCP_OK);
			step(1);
			chk("command pulse", 16'(1 << b), {13'h0, rev_cmd, fwd_cmd, stop_cmd});
			step(1);
			chk("command pulse end", 16'h0000, {13'h0, rev_cmd, fwd_cmd, stop_cmd});
		end
		acc(1'b1, `DCP_ADDR_RUNCTL, 16'h0004, DCP_OK);
		step(1);
		chk("no repeat pulse", 16'h0000, {13'h0, rev_cmd, fwd_cmd, stop_cmd});
		acc(1'b1, `DCP_ADDR_RUNCTL, 16'h0030, DCP_OK);
		step(1);
		chk("emergency stop", 16'h0001, {15'h0, estop_cmd});
		rd_chk(`DCP_ADDR_RUNCTL, 16'h0010);
		acc(1'b1, `DCP_ADDR_RUNCTL, 16'h0000, DCP_OK);
		for (int i = 0; i < 10; i++) begin
			cmd_source = dcp_src_e'(i % 4);
			freq_source = fs[i];
			ex = {1'b0, (i == 9) ? 7'h1f : fs[i], 2'(i % 4), 6'h00};
			rd_chk(`DCP_ADDR_RUNCTL, ex);
		end
		net_error = 1'b1;
		step(1);
		net_error = 1'b0;
		rd_chk(`DCP_ADDR_RUNCTL, 16'h9f40);
		acc(1'b1, `DCP_ADDR_RUNCTL, 16'h0000, DCP_OK);
		rd_chk(`DCP_ADDR_RUNCTL, 16'h1f40);
		$display("test run word done");
		for (int k = 0; k < 3; k++) begin
			fault_event = 1'b1;
			step(1);
			fault_event = 1'b0;
			step(1);
			chk("fault latch", 16'h0001, {15'h0, fault_active});
			if (k == 0) rd_chk(`DCP_ADDR_STATE, 16'h0009);
			acc(1'b1, `DCP_ADDR_RUNCTL, (k == 2) ? 16'h0000 : 16'h0008, DCP_OK);
			acc(1'b1, `DCP_ADDR_RUNCTL, 16'h0008, DCP_OK);
			step(2);
			chk("fault reset", {15'h0, k == 1}, {15'h0, fault_active});
		end
		for (int j = 0; j < 4; j++) begin
			{motor_reverse, motor_running} = 2'(j);
			{motor_decel, motor_accel} = 2'(j ^ 1);
			rd_chk(`DCP_ADDR_STATE, st_ex[j]);
		end
		acc(1'b1, `DCP_ADDR_RAMPUP, 16'h0010, DCP_ERR_WMODE);
		motor_running = 1'b0;
		acc(1'b1, `DCP_ADDR_RAMPUP, 16'h1770, DCP_OK);
		acc(1'b1, `DCP_ADDR_RAMPDN, 16'h1771, DCP_ERR_VALUE);
		rd_chk(`DCP_ADDR_RAMPDN, 16'h0064);
		acc(1'b1, `DCP_ADDR_SETPOINT, 16'hffff, DCP_OK);
		step(1);
		chk("ramp copy", 16'h1770, ramp_up_time);
		chk("setpoint copy", 16'hffff, speed_setpoint);
		chk("ramp down copy", 16'h0064, ramp_down_time);
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, 16'(9 + i), 16'h5555, DCP_ERR_WMODE);
			rd_chk(16'(9 + i), meas[i]);
		end
		acc(1'b0, 16'h0004, 16'h0000, DCP_ERR_ADDR);
		acc(1'b1, 16'h000f, 16'h0001, DCP_ERR_ADDR);
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		rd_chk(`DCP_ADDR_RAMPUP, 16'h0064);
		$display("test limits done");
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
